// ===== card_cmd_cfg.svh
`ifndef CARD_CMD_CFG_SVH
`define CARD_CMD_CFG_SVH

// Register byte offsets
`define OFS_CONFIG 6'h00
`define OFS_STATUS 6'h04
`define OFS_ARG 6'h08
`define OFS_RCA 6'h0C
`define OFS_SIZES 6'h10
`define OFS_RECORD0 6'h14
`define OFS_RECORD1 6'h18
`define OFS_RECORD2 6'h1C
`define OFS_RECORD3 6'h20

// Configuration register fields
`define CFG_SIZE_FACTOR_LSB 0
`define CFG_BASE_LSB 3
`define CFG_LAYOUT_GRP 8
`define CFG_FORMAT_LSB 9
`define CFG_ECC_LSB 11
`define CFG_TEMP_LOCK 13
`define CFG_COPY 14
`define CFG_PERM_LOCK 15
`define CFG_RESET 16'h0000

// Status register fields
`define ST_CMD_SEEN 0
`define ST_FRAME_ERR 1
`define ST_PROT_ERR 2
`define ST_UNSUPP 3
`define ST_SELECTED 4
`define ST_IDX_LSB 8
`define ST_TYPE_LSB 16
`define SIZES_FACTOR_LSB 16

// Fixed record contents
`define CLASS_MASK 12'h0F5
`define ERASE_SCALE 5'h1F
`define PROTECT_SPAN 5'h08
`define GROUP_PROT_EN 1'h1
`define DEFAULT_ECC 2'h0
`define PROG_RATIO 3'h4
`define PARTIAL_WR 1'h0
`define SIZE_FACTOR_OFFSET 4'h2

// Record bit positions
`define REC_CLASS_LSB 84
`define REC_RDLEN_LSB 80
`define REC_SIZE_FACTOR_LSB 47
`define REC_BASE_LSB 42
`define REC_SCALE_LSB 37
`define REC_SPAN_LSB 32
`define REC_GRPEN 31
`define REC_DECC_LSB 29
`define REC_RATIO_LSB 26
`define REC_WRLEN_LSB 22
`define REC_PARTIAL 21
`define REC_LAYOUT 15
`define REC_COPY 14
`define REC_PERM 13
`define REC_TEMP 12
`define REC_FORMAT_LSB 10
`define REC_ECC_LSB 8
`define REC_CRC_LSB 1
`define REC_END 0

// Command frame
`define FRAME_BITS 48
`define FRAME_CNT_LAST 6'h2F
`define FRAME_CRC_LAST 6'h27
`define CRC_POLY 7'h09

`endif

// ===== card_cmd_pkg.sv
package card_cmd_pkg;

  typedef enum logic [1:0] {
    broadcast_no_reply = 2'b00,
    broadcast_reply = 2'b01,
    addressed_command = 2'b10,
    addressed_payload = 2'b11
  } cmd_kind_type;

  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_shift = 2'b01,
    rx_check = 2'b10
  } rx_state_type;

  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
    cmd_kind_type kind;
    logic reply_due;
    logic protect_err;
  } cmd_info_type;

endpackage : card_cmd_pkg

// ===== card_cmd_frame.sv
// Summary of operation
// - Erase unit is (base+1) times (scale+1); the 10-bit size register reads zero when base is 31
// - Erase scale field always reads 0x1F
// - Size factor is two to (code+2)
// - Protect group span field holds eight
// - Group protection allowed bit reads one
// - Recommended error code field reads zero
// - Program time ratio code reads four
// - Partial write allowed bit fixed zero
// - Copy flag settable once, never cleared
// - Permanent lockout once set refuses writes forever
// - Temporary lockout refuses writes while set
// - File layout codes stored per group
// - Storage error code field, two bits
// - Record ends with seven-bit checksum
// - Reply when called for: 1-3 always, 9/10/13 on address match, 7 on match with a nonzero address, 0/4/15 never, others when selected
// - Basic class commands implemented
// - Block, protect, lock supported; streams not
// - Erase 35,36,38 accepted; 32-34,37 not
// - Four command kinds classified
// - Frame is exactly 48 bits
// - Bits arrive most significant first
// - Class mask reported in the record
// - Class mask fixed at 0x0F5
// - Block length code below twelve
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "card_cmd_cfg.svh"

module card_cmd_frame
  import card_cmd_pkg::*;
#(
  parameter logic [3:0] WRITE_LEN_CODE = 4'h9, // Write block length code
  parameter logic [3:0] READ_LEN_CODE = 4'h9 // Read block length code
) (
  input wire logic clk_sys_i, // System clock, 50 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic [5:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic bus_clk_i, // Host bus clock pin
  input wire logic cmd_line_i, // Command line pin
  output logic cmd_valid_o, // One-cycle pulse: command taken
  output cmd_info_type cmd_o // Last decoded command
);

  if (WRITE_LEN_CODE > 4'hB || READ_LEN_CODE > 4'hB) begin : g_len_check
    $error("block length code above eleven is reserved");
  end

  function automatic logic [6:0] crc7_step(input logic [6:0] crc,
                                           input logic bit_in);
    logic fb;
    fb = crc[6] ^ bit_in;
    crc7_step = {crc[5:0], 1'b0} ^ (fb ? `CRC_POLY : 7'h00);
  endfunction : crc7_step

  function automatic logic [6:0] crc7_record(input logic [119:0] bits);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = crc7_step(c, bits[i]);
    end
    crc7_record = c;
  endfunction : crc7_record

  function automatic logic cmd_supported(input logic [5:0] idx);
    case (idx)
      6'd0, 6'd1, 6'd2, 6'd3, 6'd4, 6'd7, 6'd9, 6'd10,
      6'd12, 6'd13, 6'd15: cmd_supported = 1'b1;
      6'd16, 6'd17, 6'd18, 6'd24, 6'd25, 6'd26, 6'd27,
      6'd28, 6'd29, 6'd30, 6'd42: cmd_supported = 1'b1;
      6'd35, 6'd36, 6'd38: cmd_supported = 1'b1;
      default: cmd_supported = 1'b0;
    endcase
  endfunction : cmd_supported

  function automatic cmd_kind_type cmd_kind(input logic [5:0] idx);
    case (idx)
      6'd0, 6'd4: cmd_kind = broadcast_no_reply;
      6'd1, 6'd2: cmd_kind = broadcast_reply;
      6'd17, 6'd18, 6'd24, 6'd25, 6'd26, 6'd27, 6'd30,
      6'd42: cmd_kind = addressed_payload;
      default: cmd_kind = addressed_command;
    endcase
  endfunction : cmd_kind

  function automatic logic cmd_alters(input logic [5:0] idx);
    case (idx)
      6'd24, 6'd25, 6'd26, 6'd27, 6'd28, 6'd29,
      6'd35, 6'd36, 6'd38: cmd_alters = 1'b1;
      default: cmd_alters = 1'b0;
    endcase
  endfunction : cmd_alters

  // Bus slave
  logic ack_r;
  logic [31:0] rdata_r;
  logic [15:0] config_r;
  logic [4:0] status_r;
  logic [15:0] rca_r;
  logic selected_r;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_mux;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr_take = avs_write_i & ack_r;
  assign rd_take = avs_read_i & ~ack_r;
  assign avs_readdata_o = rdata_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  // Record fields
  logic [2:0] size_factor_code;
  logic [4:0] unit_base;
  logic [127:0] record_body;
  logic [127:0] record;
  logic [9:0] erase_unit_size;
  logic [9:0] size_factor;

  assign size_factor_code = config_r[`CFG_SIZE_FACTOR_LSB +: 3];
  assign unit_base = config_r[`CFG_BASE_LSB +: 5];
  assign erase_unit_size = 10'((unit_base + 10'h001) *
                               (`ERASE_SCALE + 10'h001));
  assign size_factor = 10'(10'h001 << (size_factor_code + `SIZE_FACTOR_OFFSET));

  always_comb begin
    record_body = '0;
    record_body[`REC_CLASS_LSB +: 12] = `CLASS_MASK;
    record_body[`REC_RDLEN_LSB +: 4] = READ_LEN_CODE;
    record_body[`REC_SIZE_FACTOR_LSB +: 3] = size_factor_code;
    record_body[`REC_BASE_LSB +: 5] = unit_base;
    record_body[`REC_SCALE_LSB +: 5] = `ERASE_SCALE;
    record_body[`REC_SPAN_LSB +: 5] = `PROTECT_SPAN;
    record_body[`REC_GRPEN] = `GROUP_PROT_EN;
    record_body[`REC_DECC_LSB +: 2] = `DEFAULT_ECC;
    record_body[`REC_RATIO_LSB +: 3] = `PROG_RATIO;
    record_body[`REC_WRLEN_LSB +: 4] = WRITE_LEN_CODE;
    record_body[`REC_PARTIAL] = `PARTIAL_WR;
    record_body[`REC_LAYOUT] = config_r[`CFG_LAYOUT_GRP];
    record_body[`REC_COPY] = config_r[`CFG_COPY];
    record_body[`REC_PERM] = config_r[`CFG_PERM_LOCK];
    record_body[`REC_TEMP] = config_r[`CFG_TEMP_LOCK];
    record_body[`REC_FORMAT_LSB +: 2] = config_r[`CFG_FORMAT_LSB +: 2];
    record_body[`REC_ECC_LSB +: 2] = config_r[`CFG_ECC_LSB +: 2];
    record_body[`REC_END] = 1'b1;
    record = record_body;
    record[`REC_CRC_LSB +: 7] = crc7_record(record_body[127:8]);
  end

  // Configuration: copy and permanent lockout only ever set
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      config_r <= `CFG_RESET;
    end else if (wr_take && avs_address_i == `OFS_CONFIG) begin
      if (avs_byteenable_i[0]) begin
        config_r[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        config_r[12:8] <= avs_writedata_i[12:8];
        config_r[`CFG_TEMP_LOCK] <= avs_writedata_i[`CFG_TEMP_LOCK];
        config_r[`CFG_COPY] <= config_r[`CFG_COPY] |
                               avs_writedata_i[`CFG_COPY];
        config_r[`CFG_PERM_LOCK] <= config_r[`CFG_PERM_LOCK] |
                                    avs_writedata_i[`CFG_PERM_LOCK];
      end
    end
  end

  // Link pin synchronisers and bus clock edge
  logic [1:0] clk_sync_r;
  logic [1:0] line_sync_r;
  logic clk_prev_r;
  logic bit_strobe;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sync_r <= 2'b00;
      line_sync_r <= 2'b11;
      clk_prev_r <= 1'b0;
    end else begin
      clk_sync_r <= {clk_sync_r[0], bus_clk_i};
      line_sync_r <= {line_sync_r[0], cmd_line_i};
      clk_prev_r <= clk_sync_r[1];
    end
  end

  assign bit_strobe = clk_sync_r[1] & ~clk_prev_r;
  // Frame receiver
  rx_state_type state_r;
  rx_state_type state_nxt;
  logic [5:0] bit_cnt_r;
  logic [46:0] shift_r;
  logic [6:0] crc_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rx_idle: if (bit_strobe && !line_sync_r[1]) state_nxt = rx_shift;
      rx_shift: begin
        if (bit_strobe && bit_cnt_r == `FRAME_CNT_LAST) begin
          state_nxt = rx_check;
        end
      end
      rx_check: state_nxt = rx_idle;
      default: state_nxt = rx_idle;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= rx_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_r <= 6'h00;
      shift_r <= '0;
      crc_r <= 7'h00;
    end else if (state_r == rx_idle) begin
      bit_cnt_r <= 6'h01;
      crc_r <= crc7_step(7'h00, 1'b0);
      shift_r <= '0;
    end else if (state_r == rx_shift && bit_strobe) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
      shift_r <= {shift_r[45:0], line_sync_r[1]};
      if (bit_cnt_r <= `FRAME_CRC_LAST) begin
        crc_r <= crc7_step(crc_r, line_sync_r[1]);
      end
    end
  end

  // Frame fields: shift_r[46] direction, [45:40] index, [39:8] arg
  logic frame_good;
  logic [5:0] rx_idx;
  logic [31:0] rx_arg;
  logic supported;
  logic locked;
  logic refused;
  logic execute;
  logic addr_match;
  logic reply;

  assign rx_idx = shift_r[45:40];
  assign rx_arg = shift_r[39:8];
  assign frame_good = shift_r[46] && shift_r[0] &&
                      shift_r[7:1] == crc_r;
  assign supported = cmd_supported(rx_idx);
  assign locked = config_r[`CFG_PERM_LOCK] | config_r[`CFG_TEMP_LOCK];
  assign refused = cmd_alters(rx_idx) & locked;
  assign execute = state_r == rx_check && frame_good && supported;
  assign addr_match = rx_arg[31:16] == rca_r;

  always_comb begin
    case (rx_idx)
      6'd0, 6'd4, 6'd15: reply = 1'b0;
      6'd1, 6'd2, 6'd3: reply = 1'b1;
      6'd7: reply = addr_match && rca_r != 16'h0000;
      6'd9, 6'd10, 6'd13: reply = addr_match;
      default: reply = selected_r;
    endcase
  end

  // Card address and selection
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rca_r <= 16'h0000;
      selected_r <= 1'b0;
    end else if (execute) begin
      if (rx_idx == 6'd0) begin
        rca_r <= 16'h0000;
        selected_r <= 1'b0;
      end else if (rx_idx == 6'd3) begin
        rca_r <= rx_arg[31:16];
      end else if (rx_idx == 6'd7) begin
        selected_r <= addr_match && rca_r != 16'h0000;
      end
    end
  end

  // Command output
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
    end else begin
      cmd_valid_o <= execute;
      if (execute) begin
        cmd_o.index <= rx_idx;
        cmd_o.arg <= rx_arg;
        cmd_o.kind <= cmd_kind(rx_idx);
        cmd_o.reply_due <= reply;
        cmd_o.protect_err <= refused;
      end
    end
  end

  // Sticky status: hardware set wins over software clear
  logic [4:0] st_set;
  logic [4:0] st_clr;

  assign st_set = {1'b0, state_r == rx_check && frame_good && !supported,
                   execute && refused, state_r == rx_check && !frame_good,
                   execute};
  assign st_clr = (wr_take && avs_address_i == `OFS_STATUS &&
                   avs_byteenable_i[0]) ? avs_writedata_i[4:0] : 5'h00;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= 5'h00;
    end else begin
      status_r <= ({1'b0, status_r[3:0]} & ~st_clr) | st_set;
    end
  end
  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_i == `OFS_CONFIG) begin
      rd_mux[15:0] = config_r;
    end else if (avs_address_i == `OFS_STATUS) begin
      rd_mux[3:0] = status_r[3:0];
      rd_mux[`ST_SELECTED] = selected_r;
      rd_mux[`ST_IDX_LSB +: 6] = cmd_o.index;
      rd_mux[`ST_TYPE_LSB +: 2] = cmd_o.kind;
    end else if (avs_address_i == `OFS_ARG) begin
      rd_mux = cmd_o.arg;
    end else if (avs_address_i == `OFS_RCA) begin
      rd_mux[15:0] = rca_r;
    end else if (avs_address_i == `OFS_SIZES) begin
      rd_mux[9:0] = erase_unit_size;
      rd_mux[`SIZES_FACTOR_LSB +: 10] = size_factor;
    end else if (avs_address_i == `OFS_RECORD0) begin
      rd_mux = record[31:0];
    end else if (avs_address_i == `OFS_RECORD1) begin
      rd_mux = record[63:32];
    end else if (avs_address_i == `OFS_RECORD2) begin
      rd_mux = record[95:64];
    end else if (avs_address_i == `OFS_RECORD3) begin
      rd_mux = record[127:96];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= rd_mux;
    end
  end

endmodule : card_cmd_frame

// ===== card_cmd_frame_sva.sv
`timescale 1ns/1ps
`include "card_cmd_cfg.svh"

module card_cmd_frame_sva
  import card_cmd_pkg::*;
#(
  parameter logic [3:0] WRITE_LEN_CODE = 4'h9 // Write block length code
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Reset, active high
  input wire logic [5:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o, // Stall
  input wire logic cmd_valid_o, // Command taken pulse
  input wire cmd_info_type cmd_o // Decoded command
);
  wire logic rd_done = avs_read_i && !avs_waitrequest_o;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest longer than one cycle");
  property p_pulse;
    cmd_valid_o |=> !cmd_valid_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("command pulse longer than one cycle");
  property p_hold;
    !cmd_valid_o |-> $stable(cmd_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("command output changed without a pulse");
  property p_class;
    rd_done && avs_address_i == `OFS_RECORD2 |->
      avs_readdata_o[31:20] == 12'h0F5;
  endproperty
  a_class: assert property (p_class)
    else $error("class mask wrong");
  property p_scale;
    rd_done && avs_address_i == `OFS_RECORD1 |->
      avs_readdata_o[9:5] == 5'h1F && avs_readdata_o[4:0] == 5'h08;
  endproperty
  a_scale: assert property (p_scale)
    else $error("erase scale or protect span wrong");
  property p_fixed;
    rd_done && avs_address_i == `OFS_RECORD0 |-> avs_readdata_o[31:26] ==
      6'h24 && avs_readdata_o[25:22] == WRITE_LEN_CODE &&
      !avs_readdata_o[21] && avs_readdata_o[0];
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed record fields wrong");
  property p_unmapped;
    rd_done && avs_address_i > `OFS_RECORD3 |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_unsupp;
    cmd_valid_o |->
      !(cmd_o.index inside {6'h0B, 6'h14, 6'h20, 6'h21, 6'h22, 6'h25});
  endproperty
  a_unsupp: assert property (p_unsupp)
    else $error("unsupported command taken");
  property p_kind;
    cmd_valid_o && cmd_o.index inside {6'h00, 6'h04} |->
      cmd_o.kind == broadcast_no_reply && !cmd_o.reply_due;
  endproperty
  a_kind: assert property (p_kind)
    else $error("broadcast command kind or reply wrong");
  property p_reply;
    cmd_valid_o && cmd_o.index inside {6'h01, 6'h02} |->
      cmd_o.kind == broadcast_reply && cmd_o.reply_due;
  endproperty
  a_reply: assert property (p_reply)
    else $error("broadcast reply command wrong");
endmodule : card_cmd_frame_sva

bind card_cmd_frame card_cmd_frame_sva
  #(.WRITE_LEN_CODE(WRITE_LEN_CODE)) u_sva (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o));

// ===== host_model.sv
`timescale 1ns/1ps

module host_model (
  output logic bus_clk_o, // Bus clock, still between frames
  output logic cmd_line_o // Command line, idle high
);
  initial begin
    bus_clk_o = 1'b0;
    cmd_line_o = 1'b1;
  end
  // Two idle bits either side; data changes while the clock is low
  task automatic send_frame(input logic [47:0] f);
    #7;
    for (int i = 49; i >= -2; i--) begin
      cmd_line_o = (i > 47 || i < 0) ? 1'b1 : f[i];
      #80 bus_clk_o = 1'b1;
      #80 bus_clk_o = 1'b0;
    end
  endtask : send_frame
endmodule : host_model

// ===== tb.sv
`timescale 1ns/1ps
`include "card_cmd_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  import card_cmd_pkg::*;
  logic clk_sys_i, rst_i, avs_read_i, avs_write_i, bus_clk, cmd_line;
  logic avs_waitrequest_o, cmd_valid_o, sel;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd, wd;
  logic [127:0] rec;
  logic [15:0] lfsr, rca;
  logic [6:0] c;
  logic [4:0] b;
  logic [2:0] m;
  cmd_info_type cmd_o;
  cmd_info_type exp_q[$];
  cmd_info_type exp_e;
  int errors, total_checks;
  logic [5:0] good_ids [25] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07,
    6'h09, 6'h0A, 6'h0C, 6'h0D, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h18, 6'h19,
    6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h23, 6'h24, 6'h26, 6'h2A};
  logic [5:0] bad_ids [6] = '{6'h0B, 6'h14, 6'h20, 6'h21, 6'h22, 6'h25};

  card_cmd_frame u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .bus_clk_i(bus_clk),
    .cmd_line_i(cmd_line), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o));
  host_model u_host (.bus_clk_o(bus_clk), .cmd_line_o(cmd_line));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt

  function automatic logic [6:0] crc(input logic [6:0] s, input logic d);
    return {s[5:0], 1'b0} ^ ((s[6] ^ d) ? 7'h09 : 7'h00);
  endfunction : crc

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) begin
      errors++;
      end_of_test();
    end
    @(posedge clk_sys_i);
  endtask : bus

  task automatic send(input logic [5:0] idx, input logic [31:0] arg,
                      input logic bad);
    logic [47:0] f;
    logic [6:0] s;
    f = {2'b01, idx, arg, 8'h01};
    s = 7'h00;
    for (int i = 47; i >= 8; i--) s = crc(s, f[i]);
    f[7:1] = s ^ {6'h00, bad};
    u_host.send_frame(f);
    repeat (8) @(posedge clk_sys_i);
  endtask : send

  // Notes the expected decode, then sends a well-formed frame
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
                     input logic lock);
    cmd_info_type e;
    e.index = idx;
    e.arg = arg;
    e.protect_err = lock;
    case (idx)
      6'h00, 6'h04: e.kind = broadcast_no_reply;
      6'h01, 6'h02: e.kind = broadcast_reply;
      6'h11, 6'h12, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1E, 6'h2A:
        e.kind = addressed_payload;
      default: e.kind = addressed_command;
    endcase
    case (idx)
      6'h00, 6'h04, 6'h0F: e.reply_due = 1'b0;
      6'h01, 6'h02, 6'h03: e.reply_due = 1'b1;
      6'h09, 6'h0A, 6'h0D: e.reply_due = arg[31:16] == rca;
      6'h07: e.reply_due = arg[31:16] == rca && rca != 16'h0000;
      default: e.reply_due = sel;
    endcase
    if (idx == 6'h00) rca = 16'h0000;
    if (idx == 6'h00) sel = 1'b0;
    if (idx == 6'h03) rca = arg[31:16];
    if (idx == 6'h07) sel = arg[31:16] == rca && rca != 16'h0000;
    exp_q.push_back(e);
    send(idx, arg, 1'b0);
  endtask : cmd

  always @(posedge clk_sys_i) begin
    if (cmd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(cmd_valid_o, 1'b0)
      end else begin
        exp_e = exp_q.pop_front();
        `CHK(cmd_o, exp_e)
      end
    end
  end

  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    lfsr = 16'h0001;
    rca = 16'h0000;
    sel = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    bus(1'b0, `OFS_CONFIG, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b0, 6'h3C, 32'h0, rd);
    repeat (4) begin
      lfsr = nxt(lfsr);
      m = lfsr[2:0];
      b = lfsr[7:3] % 5'h1F;
      wd = {19'h0, lfsr[12:8], b, m};
      bus(1'b1, `OFS_CONFIG, wd, rd);
      bus(1'b0, `OFS_CONFIG, 32'h0, rd);
      `CHK(rd, wd)
      bus(1'b0, `OFS_SIZES, 32'h0, rd);
      `CHK(rd, {6'h00, 10'(32'h4 << m), 6'h00,
                10'((b + 32'h1) * 32'h20)})
      for (int k = 0; k < 4; k++) begin
        bus(1'b0, 6'h14 + 6'(4 * k), 32'h0, rd);
        rec[32 * k +: 32] = rd;
      end
      `CHK(rec[49:42], {m, b})
      `CHK(rec[15:8], {lfsr[8], 3'h0, lfsr[10:9], lfsr[12:11]})
      c = 7'h00;
      for (int i = 127; i >= 8; i--) c = crc(c, rec[i]);
      `CHK(rec[7:0], {c, 1'b1})
    end
    foreach (good_ids[i]) begin
      lfsr = nxt(lfsr);
      cmd(good_ids[i], {lfsr, ~lfsr}, 1'b0);
    end
    cmd(6'h03, 32'hABCD_0000, 1'b0);
    cmd(6'h07, 32'hABCD_0005, 1'b0);
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    `CHK(rd[4], 1'b1)
    bus(1'b0, `OFS_RCA, 32'h0, rd);
    `CHK(rd, 32'h0000_ABCD)
    cmd(6'h09, 32'hABCD_0000, 1'b0);
    cmd(6'h11, 32'h0000_0200, 1'b0);
    cmd(6'h0D, 32'h1111_0000, 1'b0);
    cmd(6'h07, 32'h0000_0000, 1'b0);
    cmd(6'h11, 32'h0000_0400, 1'b0);
    foreach (bad_ids[i]) begin
      bus(1'b1, `OFS_STATUS, 32'hF, rd);
      send(bad_ids[i], 32'h0, 1'b0);
      bus(1'b0, `OFS_STATUS, 32'h0, rd);
      `CHK(rd[3], 1'b1)
    end
    bus(1'b1, `OFS_STATUS, 32'hF, rd);
    send(6'h11, 32'h0, 1'b1);
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    `CHK(rd[1], 1'b1)
    bus(1'b1, `OFS_CONFIG, 32'h2000, rd);
    cmd(6'h18, 32'h0000_0800, 1'b1);
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    `CHK(rd[3:0], 4'h7)
    cmd(6'h11, 32'h0000_0800, 1'b0);
    bus(1'b1, `OFS_CONFIG, 32'h0, rd);
    cmd(6'h18, 32'h0000_0A00, 1'b0);
    bus(1'b1, `OFS_CONFIG, 32'h4000, rd);
    bus(1'b1, `OFS_CONFIG, 32'h8000, rd);
    bus(1'b1, `OFS_CONFIG, 32'h0, rd);
    bus(1'b0, `OFS_CONFIG, 32'h0, rd);
    `CHK(rd[15:13], 3'h6)
    cmd(6'h26, 32'h0, 1'b1);
    cmd(6'h19, 32'h0000_0200, 1'b1);
    bus(1'b0, `OFS_RECORD0, 32'h0, rd);
    `CHK(rd[14:12], 3'h6)
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule : tb
